// File: hdl/pmbc_ctrl.sv
/*
 Processor memory bus control: request flags, acknowledge and restart
 handling, stop and split-cycle sync, nonexistent-memory timeout and the
 console indicator latch, with an APB register slave.
 Assumes memory answers with one-cycle acknowledge and read restart
 pulses on the bus side, synchronous to pclk.
*/
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps

// Summary of operation
// R01 - Write drives bus data bits only where the buffer holds ones.
// R02 - Read enables receive; each arriving data pulse sets its buffer bit.
// R03 - Completion at the switch address reloads the indicator latch from buffer.
// R04 - Write timeout completion also reloads the latch at the switch address.
// R05 - Examine/deposit next loads the latch on the subroutine return pulse.
// R06 - Read, write and combined read/write; combined only when not split.
// R07 - Every request raises a general request; read types clear the buffer. Code raises it only while idle.
// R08 - Write-back restart comes from store step, or indexing subroutine.
// R09 - Read sets read clears write; write opposite; read/write sets both.
// R10 - Requests clear stop, set request flag after mode-dependent delay.
// R11 - User address over limit aborts to final step and interrupts.
// R12 - Bus request only when request flag and read or write flag set.
// R13 - Memory stop key or address-match stop sets stop on delayed request.
// R14 - Acknowledge clears request; for write also restarts, drives, returns.
// R15 - Read waits for memory read restart; the restart clears read flag.
// R16 - With stop set restarts give no return; continue key gives it.
// R17 - Read/write second half: own restart writes, drives data, returns.
// R18 - 100 us without requests while requested raises nonexistent error.
// R19 - Unless disabled, timeout simulates acknowledge; reads get extra return.
// R20 - Address-cycle step sets split sync when a stop option is active.
// R21 - Maintenance switch overrides setting of the split sync flag.
// R22 - Read/write sets stop sync; other restart sends write restart.
// R23 - Reset clears read, write, request, stop and sync flags.
module pmbc_ctrl
	import pmbc_pkg::*;
#(
	parameter int unsigned TIMEOUT = TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Memory bus
	output pmbc_req_t        mem_req,
	output pmbc_data_t       mem_wdata,
	output logic             mem_wr_restart,
	output logic             mem_rd_enable,
	input  wire logic        mem_ack,
	input  wire logic        mem_rd_restart,
	input  wire pmbc_data_t  mem_rdata,
	// Processor sequence
	output logic             ret_pulse,
	output logic             illegal_pulse,
	output logic             nxm_pulse,
	output logic [35:0]      indicator
);

	logic [CTL_W-1:0] ctrl;
	logic [17:0]      addr;
	logic [17:0]      sw_addr;
	logic [7:0]       limit;
	logic [35:0]      wdata;
	logic [35:0]      membuf;
	logic [35:0]      ind;
	logic             rd_f, wr_f, rq_f, stop_f, split_f, ssync_f;
	logic             nxm_f, ill_f, done_f, pend_rw, next_f;
	pmbc_state_t      state;
	logic [7:0]       dly;
	logic [$clog2(TIMEOUT+1)-1:0] tmo;
	logic             ret_q, wrr_q, ill_q, nxm_q;
	logic [31:0]      rdata_q;
	logic             pready_q;

	// APB decode
	wire        acc     = psel & penable & ~pready_q;
	// Writes commit at the edge where the master sees pready
	wire        wr_acc  = psel & penable & pready_q & pwrite;
	wire        hit_ctl = paddr == OFS_CTRL;
	wire        hit_cmd = paddr == OFS_CMD;
	wire [11:0] cmd     = (wr_acc & hit_cmd) ? pwdata[11:0] : 12'h000;
	wire        mapped  = paddr inside {OFS_CTRL, OFS_CMD, OFS_ADDR,
		OFS_WDATA, OFS_WDATAH, OFS_BUF, OFS_BUFH, OFS_IND, OFS_INDH,
		OFS_STAT, OFS_SWADDR, OFS_LIMIT};

	wire idle     = state == PMBC_IDLE && !rq_f;
	wire user     = ctrl[CTL_USER];
	wire do_split = split_f;
	// R06 R20: combined access only unsplit; split issues separate ones
	wire req_rd   = cmd[CMD_READ] | (cmd[CMD_FETCH] & do_split);
	// Write-back step of a pending fetch-and-pause
	wire wb_step  = (cmd[CMD_STORE] | cmd[CMD_INDEX]) & pend_rw;
	wire req_wr   = cmd[CMD_WRITE] | (wb_step & do_split);
	wire req_rw   = cmd[CMD_FETCH] & ~do_split;
	// R07 general request
	wire gen_req  = (req_rd | req_wr | req_rw) & idle;
	wire dly_end  = state == PMBC_DELAY && dly == 8'h00;
	wire over     = user & (addr[17:10] > limit);
	wire amatch   = addr == sw_addr;
	// R08: restart from store step or indexing subroutine
	wire rw_rst   = wb_step & ~do_split;
	wire tmo_hit  = rq_f & tmo == '0 & ~stop_f & state == PMBC_WAIT;
	wire sim_ack  = tmo_hit & ~ctrl[CTL_MDIS]; // R19
	wire ack      = (mem_ack & rq_f) | sim_ack;
	// R14 write acknowledge restarts; R17 own read/write restart
	wire wr_done  = (ack & wr_f & ~rd_f) | rw_rst;
	wire rd_done  = (mem_rd_restart & rd_f & ~rq_f) | (sim_ack & rd_f);
	// R16 stop blocks memory restarts from returning
	wire ret_now  = ((wr_done | rd_done) & ~stop_f) | cmd[CMD_MCONT];
	// R22 abandoned read/write finishes by write restart
	wire kt_wrr   = cmd[CMD_OTHER] & ssync_f;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl    <= CTRL_RST;
			addr    <= ADDR_RST;
			sw_addr <= ADDR_RST;
			limit   <= LIMIT_RST;
			wdata   <= '0;
		end else if (wr_acc) begin
			if (hit_ctl)
				ctrl <= pwdata[CTL_W-1:0];
			if (paddr == OFS_ADDR && idle)
				addr <= pwdata[17:0];
			if (paddr == OFS_SWADDR)
				sw_addr <= pwdata[17:0];
			if (paddr == OFS_LIMIT)
				limit <= pwdata[7:0];
			if (paddr == OFS_WDATA)
				wdata[31:0] <= pwdata;
			if (paddr == OFS_WDATAH)
				wdata[35:32] <= pwdata[3:0];
		end
	end

	// Request flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_f <= 1'b0;
			wr_f <= 1'b0;
			rq_f <= 1'b0;
			stop_f <= 1'b0;
			ssync_f <= 1'b0;
			split_f <= 1'b0;
			pend_rw <= 1'b0;
			state <= PMBC_IDLE;
			dly <= 8'h00;
		end else if (cmd[CMD_RESET]) begin
			rd_f <= 1'b0; // R23
			wr_f <= 1'b0;
			rq_f <= 1'b0;
			stop_f <= 1'b0;
			ssync_f <= 1'b0;
			split_f <= 1'b0;
			pend_rw <= 1'b0;
			state <= PMBC_IDLE;
		end else begin
			if (gen_req) begin
				rd_f <= req_rd | req_rw; // R09
				wr_f <= req_wr | req_rw;
				stop_f <= 1'b0; // R10
				state <= PMBC_DELAY;
				dly <= user ? USER_DLY_CYC : EXEC_DLY_CYC; // R10
				if (req_rw)
					ssync_f <= 1'b1; // R22
				// Split fetch also leaves a write-back pending
				if (cmd[CMD_FETCH])
					pend_rw <= 1'b1;
			end else if (state == PMBC_DELAY) begin
				dly <= dly - 8'h01;
				if (dly_end) begin
					rq_f <= ~over; // R11
					state <= over ? PMBC_IDLE : PMBC_WAIT;
					// R13
					if (cmd[CMD_MSTOP] | (ctrl[CTL_ASTOP] & amatch))
						stop_f <= 1'b1;
				end
			end
			if (ack)
				rq_f <= 1'b0; // R14
			if (rd_done)
				rd_f <= 1'b0; // R15
			// Write-back step or other restart ends the pending write-back and stop sync
			if (wb_step | kt_wrr) begin
				pend_rw <= 1'b0;
				ssync_f <= 1'b0;
			end
			if (rw_rst | kt_wrr)
				wr_f <= 1'b0; // R17
			if (ret_now && state == PMBC_WAIT) begin
				state <= PMBC_IDLE;
				if (!rd_f)
					wr_f <= 1'b0;
			end
			// R20 R21
			if (cmd[CMD_ATSTEP])
				split_f <= (cmd[CMD_MSTOP] | ctrl[CTL_ASTOP]) &
					~ctrl[CTL_NOSPLIT];
		end
	end

	// R18 request watchdog, rearmed by every general request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tmo <= '0;
		else if (gen_req)
			tmo <= ($bits(tmo))'(TIMEOUT);
		else if (tmo != '0)
			tmo <= tmo - 1'b1;
	end

	// Buffer, latch and sticky status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			membuf <= '0;
			ind <= '0;
			nxm_f <= 1'b0;
			ill_f <= 1'b0;
			done_f <= 1'b0;
			next_f <= 1'b0;
		end else begin
			if (gen_req && (req_rd || req_rw))
				membuf <= '0; // R07
			else if (mem_rd_enable && mem_rdata.strobe)
				membuf <= membuf | mem_rdata.data; // R02
			else if (gen_req && cmd[CMD_WRITE])
				membuf <= wdata;
			// R03 R04: real or timed-out completion at switch address
			if ((wr_done | rd_done) & amatch)
				ind <= membuf;
			else if (ret_now & next_f)
				ind <= membuf; // R05
			if (cmd[CMD_NEXT])
				next_f <= 1'b1;
			else if (ret_now)
				next_f <= 1'b0;
			// Set wins over software clear
			nxm_f <= tmo_hit | (nxm_f & ~cmd[CMD_CLRERR]); // R18
			ill_f <= (dly_end & over) | (ill_f & ~cmd[CMD_CLRERR]);
			done_f <= ret_now | (done_f & ~gen_req);
		end
	end

	// Registered bus and sequence outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= '0;
			mem_wdata <= '0;
			mem_wr_restart <= 1'b0;
			mem_rd_enable <= 1'b0;
			ret_q <= 1'b0;
			wrr_q <= 1'b0;
			ill_q <= 1'b0;
			nxm_q <= 1'b0;
		end else begin
			mem_req.rq <= rq_f & (rd_f | wr_f) & ~ack; // R12
			mem_req.rd <= rd_f;
			mem_req.wr <= wr_f;
			mem_req.addr <= addr;
			mem_rd_enable <= rd_f; // R02
			wrr_q <= wr_done | kt_wrr;
			mem_wr_restart <= wr_done | kt_wrr; // R14 R17 R22
			mem_wdata.strobe <= wr_done;
			mem_wdata.data <= wr_done ? membuf : '0; // R01
			ret_q <= ret_now;
			ill_q <= dly_end & over; // R11
			nxm_q <= tmo_hit; // R18
		end
	end

	assign ret_pulse     = ret_q;
	assign illegal_pulse = ill_q;
	assign nxm_pulse     = nxm_q;
	assign indicator     = ind;

	// APB read mux
	wire [31:0] stat = {22'h0, pend_rw, done_f, ill_f, nxm_f, ssync_f,
		split_f, stop_f, rq_f, wr_f, rd_f};
	wire [31:0] rmux =
		paddr == OFS_CTRL   ? {28'h0, ctrl} :
		paddr == OFS_ADDR   ? {14'h0, addr} :
		paddr == OFS_WDATA  ? wdata[31:0] :
		paddr == OFS_WDATAH ? {28'h0, wdata[35:32]} :
		paddr == OFS_BUF    ? membuf[31:0] :
		paddr == OFS_BUFH   ? {28'h0, membuf[35:32]} :
		paddr == OFS_IND    ? ind[31:0] :
		paddr == OFS_INDH   ? {28'h0, ind[35:32]} :
		paddr == OFS_STAT   ? stat :
		paddr == OFS_SWADDR ? {14'h0, sw_addr} :
		paddr == OFS_LIMIT  ? {24'h0, limit} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			rdata_q <= '0;
			pslverr <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			rdata_q <= acc & ~pwrite ? rmux : 32'h0;
			pslverr <= acc & ~mapped;
		end
	end

	assign pready = pready_q;
	assign prdata = rdata_q;

endmodule

// File: hdl/pmbc_pkg.sv
/*
 Package for the processor memory bus control block: APB register map,
 field positions, reset values, timing counts and the carried structs.
 Assumes a 250 MHz pclk.
*/
package pmbc_pkg;

	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned TIMEOUT_US    = 100;
	localparam int unsigned TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
	localparam int unsigned EXEC_DLY_NS   = 8;
	localparam int unsigned USER_DLY_NS   = 40;
	localparam logic [7:0]  EXEC_DLY_CYC  = 8'(EXEC_DLY_NS * CLK_MHZ / 1000);
	localparam logic [7:0]  USER_DLY_CYC  = 8'(USER_DLY_NS * CLK_MHZ / 1000);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0C;
	localparam logic [7:0] OFS_WDATAH = 8'h10;
	localparam logic [7:0] OFS_BUF    = 8'h14;
	localparam logic [7:0] OFS_BUFH   = 8'h18;
	localparam logic [7:0] OFS_IND    = 8'h1C;
	localparam logic [7:0] OFS_INDH   = 8'h20;
	localparam logic [7:0] OFS_STAT   = 8'h24;
	localparam logic [7:0] OFS_SWADDR = 8'h28;
	localparam logic [7:0] OFS_LIMIT  = 8'h2C;

	// CTRL fields
	localparam int CTL_USER    = 0;
	localparam int CTL_ASTOP   = 1;
	localparam int CTL_MDIS    = 2;
	localparam int CTL_NOSPLIT = 3;
	localparam int CTL_W       = 4;
	localparam logic [CTL_W-1:0] CTRL_RST = 4'h0;

	// CMD fields (write-one pulses)
	localparam int CMD_READ    = 0;
	localparam int CMD_WRITE   = 1;
	localparam int CMD_FETCH   = 2;
	localparam int CMD_STORE   = 3;
	localparam int CMD_INDEX   = 4;
	localparam int CMD_MSTOP   = 5;
	localparam int CMD_MCONT   = 6;
	localparam int CMD_OTHER   = 7;
	localparam int CMD_ATSTEP  = 8;
	localparam int CMD_NEXT    = 9;
	localparam int CMD_RESET   = 10;
	localparam int CMD_CLRERR  = 11;

	// STAT fields
	localparam int ST_RD    = 0;
	localparam int ST_WR    = 1;
	localparam int ST_RQ    = 2;
	localparam int ST_STOP  = 3;
	localparam int ST_SPLIT = 4;
	localparam int ST_SSYNC = 5;
	localparam int ST_NXM   = 6;
	localparam int ST_ILL   = 7;
	localparam int ST_DONE  = 8;
	localparam int ST_PEND  = 9;

	localparam logic [17:0] ADDR_RST  = 18'h00000;
	localparam logic [7:0]  LIMIT_RST = 8'hFF;

	typedef struct packed {
		logic        rq;
		logic        rd;
		logic        wr;
		logic [17:0] addr;
	} pmbc_req_t;

	typedef struct packed {
		logic        strobe;
		logic [35:0] data;
	} pmbc_data_t;

	typedef enum logic [1:0] {
		PMBC_IDLE  = 2'b00,
		PMBC_DELAY = 2'b01,
		PMBC_WAIT  = 2'b10
	} pmbc_state_t;

endpackage

// File: sim/pmbc_ctrl_props.sv
/*
 Assertions on the memory-bus and sequence-pulse ports of pmbc_ctrl.
 Assumes one pclk domain and active-low presetn.
*/
`timescale 1ns/10ps
module pmbc_ctrl_props
	import pmbc_pkg::*;
(
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Memory bus
	input wire pmbc_req_t  mem_req,
	input wire pmbc_data_t mem_wdata,
	input wire logic       mem_wr_restart,
	input wire logic       mem_rd_enable,
	input wire logic       mem_ack,
	input wire logic       mem_rd_restart,
	// Sequence pulses
	input wire logic       ret_pulse,
	input wire logic       illegal_pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	rq_needs_dir_a: assert property (
		mem_req.rq |-> mem_req.rd || mem_req.wr) else $error("bare request");
	ack_drops_rq_a: assert property (
		mem_ack && mem_req.rq |-> ##[0:1] !mem_req.rq) else $error("rq held");
	wr_restart_a: assert property (
		mem_ack && mem_req.rq && mem_req.wr && !mem_req.rd
		|=> mem_wr_restart && mem_wdata.strobe) else $error("no restart");
	idle_data_a: assert property (
		!mem_wdata.strobe |-> mem_wdata.data == '0) else $error("data leak");
	rd_gate_a: assert property (
		$rose(mem_req.rd) |-> ##[0:1] mem_rd_enable) else $error("no gate");
	addr_hold_a: assert property (
		mem_req.rq ##1 mem_req.rq |-> $stable(mem_req.addr))
		else $error("addr moved");
	ill_no_rq_a: assert property (
		illegal_pulse |-> !mem_req.rq ##1 !mem_req.rq) else $error("rq set");
	ret_single_a: assert property (
		ret_pulse |=> !ret_pulse) else $error("long return");

	cover property (mem_ack && mem_req.wr);
	cover property (mem_rd_restart);
	cover property (illegal_pulse);
endmodule

bind pmbc_ctrl pmbc_ctrl_props pmbc_ctrl_props_i (.pclk, .presetn,
	.mem_req, .mem_wdata, .mem_wr_restart, .mem_rd_enable, .mem_ack,
	.mem_rd_restart, .ret_pulse, .illegal_pulse);

// File: sim/pmbc_mem_model.sv
/*
 Memory module model on the far side of the bus.
 Acks four cycles after a request; mute leaves a request unanswered.
*/
`timescale 1ns/10ps
module pmbc_mem_model
	import pmbc_pkg::*;
#(
	parameter logic [35:0] RD_WORD = 36'h0F0F0F0F0
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bench control
	input  wire logic       mute,
	output logic [35:0]     got,
	// Memory bus
	input  wire pmbc_req_t  mem_req,
	input  wire pmbc_data_t mem_wdata,
	output logic            mem_ack,
	output logic            mem_rd_restart,
	output pmbc_data_t      mem_rdata
);
	logic [2:0] cnt;
	logic       pulse;

	// Idle lines show the inverse word, never a stale copy
	assign mem_rdata = {pulse, pulse ? RD_WORD : ~RD_WORD};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 3'h0;
			pulse <= 1'b0;
			mem_ack <= 1'b0;
			mem_rd_restart <= 1'b0;
			got <= 36'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rd_restart <= 1'b0;
			pulse <= 1'b0;
			cnt <= (cnt != 3'h0) ? cnt + 3'h1 : 3'h0;
			if (cnt == 3'h0 && mem_req.rq && !mute && !mem_ack)
				cnt <= 3'h1;
			if (cnt == 3'h3) begin
				mem_ack <= 1'b1;
				if (!mem_req.rd)
					cnt <= 3'h0;
			end
			if (cnt == 3'h5)
				pulse <= 1'b1;
			if (cnt == 3'h6) begin
				mem_rd_restart <= 1'b1;
				cnt <= 3'h0;
			end
			if (mem_wdata.strobe)
				got <= mem_wdata.data;
		end
	end
endmodule

// File: sim/pmbc_ctrl_test.sv
/*
 Self-checking bench for pmbc_ctrl with the memory model.
 Assumes APB at 250 MHz and a shortened timeout of 64 cycles.
*/
`timescale 1ns/10ps
module pmbc_ctrl_test;
	import pmbc_pkg::*;
	localparam logic [35:0] RDW = 36'h0F0F0F0F0;
	logic        pclk, presetn, psel, penable, pwrite, mute, slv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        pready, pslverr, mem_ack, mem_rd_restart;
	logic        mem_wr_restart, mem_rd_enable, ret_pulse;
	logic        illegal_pulse, nxm_pulse;
	logic [35:0] indicator, got, v36;
	pmbc_req_t   mem_req;
	pmbc_data_t  mem_wdata, mem_rdata;
	int          err_total = 0, checks = 0;
	int          n_ret = 0, n_ill = 0, n_nxm = 0;

	pmbc_ctrl #(.TIMEOUT(64)) pmbc_ctrl_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mem_req, .mem_wdata, .mem_wr_restart, .mem_rd_enable, .mem_ack,
		.mem_rd_restart, .mem_rdata, .ret_pulse, .illegal_pulse,
		.nxm_pulse, .indicator);
	pmbc_mem_model #(.RD_WORD(RDW)) pmbc_mem_model_i (.pclk, .presetn,
		.mute, .got, .mem_req, .mem_wdata, .mem_ack, .mem_rd_restart,
		.mem_rdata);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (ret_pulse === 1'b1) n_ret++;
		if (illegal_pulse === 1'b1) n_ill++;
		if (nxm_pulse === 1'b1) n_nxm++;
	end

	task automatic end_sim;
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (n >= 9) begin
			err_total++;
			end_sim();
		end
		rdv = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmd(input int b);
		apb(1'b1, OFS_CMD, 32'h1 << b);
	endtask
	task automatic rd36(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		v36[31:0] = rdv;
		apb(1'b0, 8'(a + 8'h04), 32'h0);
		v36[35:32] = rdv[3:0];
	endtask
	task automatic wait_n(ref int c, input int v);
		int n;
		for (n = 0; n < 400 && c < v; n++)
			@(posedge pclk);
		if (c < v) begin
			err_total++;
			end_sim();
		end
	endtask

	task automatic s_regs;
		apb(1'b0, OFS_LIMIT, 32'h0);
		chk(36'(rdv), 36'(LIMIT_RST));
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'(rdv), 36'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({slv, rdv}, 36'h100000000);
	endtask
	task automatic s_write;
		apb(1'b1, OFS_WDATA, 32'h89ABCDEF);
		apb(1'b1, OFS_WDATAH, 32'h5);
		apb(1'b1, OFS_ADDR, 32'h123);
		apb(1'b1, OFS_SWADDR, 32'h123);
		cmd(CMD_WRITE);
		wait_n(n_ret, n_ret + 1);
		rd36(OFS_IND);
		chk(v36, 36'h589ABCDEF);
		chk(got, 36'h589ABCDEF);
	endtask
	task automatic s_read;
		cmd(CMD_READ);
		wait_n(n_ret, n_ret + 1);
		rd36(OFS_BUF);
		chk(v36, RDW);
		chk(indicator, RDW);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'(rdv[ST_RD]), 36'h0);
	endtask
	task automatic s_rw;
		cmd(CMD_FETCH);
		wait_n(n_ret, n_ret + 1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'(rdv[2:0]), 36'h2);
		cmd(CMD_STORE);
		wait_n(n_ret, n_ret + 1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(got, RDW);
		chk(36'(rdv[2:0]), 36'h0);
	endtask
	task automatic s_ill;
		apb(1'b1, OFS_LIMIT, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b1, OFS_ADDR, 32'h400);
		cmd(CMD_READ);
		wait_n(n_ill, n_ill + 1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'({rdv[ST_ILL], rdv[ST_RQ]}), 36'h2);
		apb(1'b1, OFS_CTRL, 32'h0);
		cmd(CMD_CLRERR);
		cmd(CMD_RESET);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'(rdv[5:0]), 36'h0);
	endtask
	task automatic s_nxm;
		int r0;
		r0 = n_ret;
		apb(1'b1, OFS_SWADDR, 32'h400);
		mute <= 1'b1;
		cmd(CMD_WRITE);
		wait_n(n_nxm, n_nxm + 1);
		wait_n(n_ret, r0 + 1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'({rdv[ST_NXM], rdv[ST_RQ]}), 36'h2);
		rd36(OFS_IND);
		chk(v36, 36'h589ABCDEF);
		mute <= 1'b0;
	endtask
	task automatic s_stop;
		int r0;
		apb(1'b1, OFS_SWADDR, 32'h0);
		cmd(CMD_NEXT);
		cmd(CMD_READ);
		wait_n(n_ret, n_ret + 1);
		chk(indicator, RDW);
		apb(1'b1, OFS_SWADDR, 32'h400);
		apb(1'b1, OFS_CTRL, 32'h2);
		r0 = n_ret;
		cmd(CMD_READ);
		repeat (20) @(posedge pclk);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'(rdv[3:0]), 36'h8);
		chk(36'(n_ret - r0), 36'h0);
		cmd(CMD_MCONT);
		wait_n(n_ret, r0 + 1);
		apb(1'b1, OFS_SWADDR, 32'h0);
		cmd(CMD_ATSTEP);
		cmd(CMD_FETCH);
		wait_n(n_ret, n_ret + 1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'({rdv[ST_PEND], rdv[ST_SSYNC], rdv[ST_SPLIT],
			rdv[ST_WR]}), 36'hA);
		cmd(CMD_STORE);
		wait_n(n_ret, n_ret + 1);
		chk(got, RDW);
		apb(1'b1, OFS_CTRL, 32'hA);
		cmd(CMD_ATSTEP);
		cmd(CMD_FETCH);
		wait_n(n_ret, n_ret + 1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'({rdv[ST_SSYNC], rdv[ST_SPLIT]}), 36'h2);
		cmd(CMD_OTHER);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(36'({rdv[ST_PEND], rdv[ST_SSYNC], rdv[ST_WR]}), 36'h0);
	endtask

	initial begin
		{psel, penable, pwrite, mute} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_regs();
		s_write();
		s_read();
		s_rw();
		s_ill();
		s_nxm();
		s_stop();
		end_sim();
	end
endmodule
